// *** shared/iopcw_pkg.sv ***
// Shared constants for the I/O port control and change wake block
package iopcw_pkg;
    localparam logic [7:0] ADDR_P5_DATA = 8'h00;
    localparam logic [7:0] ADDR_P6_DATA = 8'h04;
    localparam logic [7:0] ADDR_P7_DATA = 8'h08;
    localparam logic [7:0] ADDR_P5_DIR = 8'h0C;
    localparam logic [7:0] ADDR_P6_DIR = 8'h10;
    localparam logic [7:0] ADDR_P7_DIR = 8'h14;
    localparam logic [7:0] ADDR_P5_PULLDOWN = 8'h18;
    localparam logic [7:0] ADDR_P5_PULLUP = 8'h1C;
    localparam logic [7:0] ADDR_P6_OPENDRAIN = 8'h20;
    localparam logic [7:0] ADDR_P5_SINK = 8'h24;
    localparam logic [7:0] ADDR_P6_SINK = 8'h28;
    localparam logic [7:0] ADDR_P5_DRIVE = 8'h2C;
    localparam logic [7:0] ADDR_P6_DRIVE = 8'h30;
    localparam logic [7:0] ADDR_P6_PULLUP = 8'h34;
    localparam logic [7:0] ADDR_WAKE_CTRL = 8'h38;
    localparam logic [7:0] ADDR_IRQ_EN = 8'h3C;
    localparam logic [7:0] ADDR_CHANGE_STAT = 8'h40;
    // Port 5 strength registers: bits 5 and 0 do not exist
    localparam logic [7:0] P5_STRENGTH_MASK = 8'hDE;
    // Bit positions of single-bit controls
    localparam int WAKE_EN_BIT = 1;
    localparam int IRQ_EN_BIT = 1;
    localparam int CHANGE_FLAG_BIT = 0;
    // Values after reset
    localparam logic [7:0] RST_DATA = 8'h00;
    localparam logic [7:0] RST_DIR = 8'hFF;
    localparam logic [7:0] RST_PULLDOWN = 8'hFF;
    localparam logic [7:0] RST_PULLUP = 8'hFF;
    localparam logic [7:0] RST_OPENDRAIN = 8'h00;
    localparam logic [7:0] RST_STRENGTH = 8'h00;
endpackage

// *** rtl/iopcw_top.sv ***
// Three 8-bit GPIO ports with APB registers and port 5 change wake
//
// Behaviour
// - Port 5 sink select exists at bits 7,6,4,3,2,1; bits 5,0 unused.
// - Sink select 0 gives normal sink, 1 gives high sink.
// - Port 6 sink select register, bit n drives pin n.
// - Port 5 drive select exists at bits 7,6,4,3,2,1; bits 5,0 unused.
// - Drive select 0 gives normal source drive, 1 gives high drive.
// - Port 6 drive select register, bit n drives pin n.
// - Port 6 pull-up bits active low: 0 enables, 1 disables.
// - Ports 5, 6 and 7 are tri-state: each pin driven or released.
// - Each port has a direction register setting each pin's direction.
// - Direction 0 makes an output, 1 makes high impedance.
// - Direction registers readable and writable; data reads return the synchronised pin levels.
// - Port 5 pull-up and pull-down enabled per pin by software.
// - Port 5 pull bits active low; pull-down bits reset to 1.
// - Port 6 pins can be open-drain individually.
// - Open-drain bit 1 open-drain, 0 push-pull; resets to 0.
// - Port 5 change acts as interrupt source, wake source, or both.
// - With change irq enabled, jump to vector if global irq on.
// - Wake enable alone resumes at the next instruction.
`timescale 1ns/1ps
module iopcw_top (
    input wire logic clk_in,
    input wire logic reset_n_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [7:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    input wire logic [7:0] p5_pin_in,
    input wire logic [7:0] p6_pin_in,
    input wire logic [7:0] p7_pin_in,
    output logic [7:0] p5_pin_out,
    output logic [7:0] p6_pin_out,
    output logic [7:0] p7_pin_out,
    output logic [7:0] p5_pin_oe_out,
    output logic [7:0] p6_pin_oe_out,
    output logic [7:0] p7_pin_oe_out,
    output logic [7:0] p5_pulldown_n_out,
    output logic [7:0] p5_pullup_n_out,
    output logic [7:0] p6_pullup_n_out,
    output logic [7:0] p5_sink_strength_sel_out,
    output logic [7:0] p6_sink_strength_sel_out,
    output logic [7:0] p5_drive_strength_sel_out,
    output logic [7:0] p6_drive_strength_sel_out,
    input wire logic core_sleeping_in,
    input wire logic global_irq_on_in,
    output logic change_irq_out,
    output logic change_wake_out,
    output logic resume_vector_out
);
    // Pin synchronisers
    logic [23:0] pin_meta;
    logic [23:0] pin_sync;
    // Register file
    logic [7:0] port5_data_reg, port6_data_reg, port7_data_reg;
    logic [7:0] port5_direction_reg, port6_direction_reg;
    logic [7:0] port7_direction_reg;
    logic [7:0] port5_pulldown_reg, port5_pullup_reg;
    logic [7:0] port6_opendrain_reg;
    logic [7:0] port5_sink_strength_select, port6_sink_strength_select;
    logic [7:0] port5_drive_strength_select, port6_drive_strength_select;
    logic [7:0] port6_pullup_disable;
    logic port_change_wake_en, port_change_irq_en;
    logic [7:0] port5_read_latch;
    logic change_flag;
    logic [31:0] prdata;
    logic pready, pslverr;
    logic [23:0] pin_out, pin_oe;
    logic change_irq, change_wake, resume_vector;
    // Next values
    logic [7:0] next_port5_data_reg, next_port6_data_reg;
    logic [7:0] next_port7_data_reg;
    logic [7:0] next_port5_direction_reg, next_port6_direction_reg;
    logic [7:0] next_port7_direction_reg;
    logic [7:0] next_port5_pulldown_reg, next_port5_pullup_reg;
    logic [7:0] next_port6_opendrain_reg;
    logic [7:0] next_port5_sink_strength_select;
    logic [7:0] next_port6_sink_strength_select;
    logic [7:0] next_port5_drive_strength_select;
    logic [7:0] next_port6_drive_strength_select;
    logic [7:0] next_port6_pullup_disable;
    logic next_port_change_wake_en, next_port_change_irq_en;
    logic [7:0] next_port5_read_latch;
    logic next_change_flag;
    logic [31:0] next_prdata;
    logic next_pready, next_pslverr;
    logic [23:0] next_pin_out, next_pin_oe;
    logic next_change_irq, next_change_wake, next_resume_vector;
    logic access, wr, rd, mapped;
    logic [7:0] rdata8;
    logic [7:0] wdata8;

    // Two flip-flops on every pin before use
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            pin_meta <= 24'h000000;
            pin_sync <= 24'h000000;
        end else begin
            pin_meta <= {p7_pin_in, p6_pin_in, p5_pin_in};
            pin_sync <= pin_meta;
        end
    end

    // Bus decode: the access completes when pready is high
    always_comb begin
        access = psel_in && penable_in && pready;
        wr = access && pwrite_in;
        rd = access && !pwrite_in;
        wdata8 = pwdata_in[7:0];
        mapped = 1'b1;
        rdata8 = 8'h00;
        unique case (paddr_in)
            iopcw_pkg::ADDR_P5_DATA: rdata8 = pin_sync[7:0];
            iopcw_pkg::ADDR_P6_DATA: rdata8 = pin_sync[15:8];
            iopcw_pkg::ADDR_P7_DATA: rdata8 = pin_sync[23:16];
            iopcw_pkg::ADDR_P5_DIR: rdata8 = port5_direction_reg;
            iopcw_pkg::ADDR_P6_DIR: rdata8 = port6_direction_reg;
            iopcw_pkg::ADDR_P7_DIR: rdata8 = port7_direction_reg;
            iopcw_pkg::ADDR_P5_PULLDOWN: rdata8 = port5_pulldown_reg;
            iopcw_pkg::ADDR_P5_PULLUP: rdata8 = port5_pullup_reg;
            iopcw_pkg::ADDR_P6_OPENDRAIN: rdata8 = port6_opendrain_reg;
            iopcw_pkg::ADDR_P5_SINK: rdata8 = port5_sink_strength_select;
            iopcw_pkg::ADDR_P6_SINK: rdata8 = port6_sink_strength_select;
            iopcw_pkg::ADDR_P5_DRIVE: rdata8 = port5_drive_strength_select;
            iopcw_pkg::ADDR_P6_DRIVE: rdata8 = port6_drive_strength_select;
            iopcw_pkg::ADDR_P6_PULLUP: rdata8 = port6_pullup_disable;
            iopcw_pkg::ADDR_WAKE_CTRL:
                rdata8[iopcw_pkg::WAKE_EN_BIT] = port_change_wake_en;
            iopcw_pkg::ADDR_IRQ_EN:
                rdata8[iopcw_pkg::IRQ_EN_BIT] = port_change_irq_en;
            iopcw_pkg::ADDR_CHANGE_STAT:
                rdata8[iopcw_pkg::CHANGE_FLAG_BIT] = change_flag;
            default: mapped = 1'b0;
        endcase
    end

    // Bus answer: one wait state, then pready with registered data
    always_comb begin
        next_pready = psel_in && penable_in && !pready;
        next_prdata = 32'h00000000;
        next_pslverr = 1'b0;
        if (next_pready) begin
            next_prdata = pwrite_in ? 32'h00000000 : {24'h000000, rdata8};
            next_pslverr = !mapped;
        end
    end

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            pready <= 1'b0;
            prdata <= 32'h00000000;
            pslverr <= 1'b0;
        end else begin
            pready <= next_pready;
            prdata <= next_prdata;
            pslverr <= next_pslverr;
        end
    end

    // Register writes and change detection
    always_comb begin
        next_port5_data_reg = port5_data_reg;
        next_port6_data_reg = port6_data_reg;
        next_port7_data_reg = port7_data_reg;
        next_port5_direction_reg = port5_direction_reg;
        next_port6_direction_reg = port6_direction_reg;
        next_port7_direction_reg = port7_direction_reg;
        next_port5_pulldown_reg = port5_pulldown_reg;
        next_port5_pullup_reg = port5_pullup_reg;
        next_port6_opendrain_reg = port6_opendrain_reg;
        next_port5_sink_strength_select = port5_sink_strength_select;
        next_port6_sink_strength_select = port6_sink_strength_select;
        next_port5_drive_strength_select = port5_drive_strength_select;
        next_port6_drive_strength_select = port6_drive_strength_select;
        next_port6_pullup_disable = port6_pullup_disable;
        next_port_change_wake_en = port_change_wake_en;
        next_port_change_irq_en = port_change_irq_en;
        next_port5_read_latch = port5_read_latch;
        next_change_flag = change_flag;
        if (wr && mapped) begin
            unique case (paddr_in)
                iopcw_pkg::ADDR_P5_DATA:
                    next_port5_data_reg = wdata8;
                iopcw_pkg::ADDR_P6_DATA: next_port6_data_reg = wdata8;
                iopcw_pkg::ADDR_P7_DATA: next_port7_data_reg = wdata8;
                iopcw_pkg::ADDR_P5_DIR:
                    next_port5_direction_reg = wdata8;
                iopcw_pkg::ADDR_P6_DIR: next_port6_direction_reg = wdata8;
                iopcw_pkg::ADDR_P7_DIR: next_port7_direction_reg = wdata8;
                iopcw_pkg::ADDR_P5_PULLDOWN:
                    next_port5_pulldown_reg = wdata8;
                iopcw_pkg::ADDR_P5_PULLUP: next_port5_pullup_reg = wdata8;
                iopcw_pkg::ADDR_P6_OPENDRAIN:
                    next_port6_opendrain_reg = wdata8;
                iopcw_pkg::ADDR_P5_SINK:
                    next_port5_sink_strength_select =
                        wdata8 & iopcw_pkg::P5_STRENGTH_MASK;
                iopcw_pkg::ADDR_P6_SINK:
                    next_port6_sink_strength_select = wdata8;
                iopcw_pkg::ADDR_P5_DRIVE:
                    next_port5_drive_strength_select =
                        wdata8 & iopcw_pkg::P5_STRENGTH_MASK;
                iopcw_pkg::ADDR_P6_DRIVE:
                    next_port6_drive_strength_select = wdata8;
                iopcw_pkg::ADDR_P6_PULLUP:
                    next_port6_pullup_disable = wdata8;
                iopcw_pkg::ADDR_WAKE_CTRL:
                    next_port_change_wake_en = wdata8[iopcw_pkg::WAKE_EN_BIT];
                iopcw_pkg::ADDR_IRQ_EN:
                    next_port_change_irq_en = wdata8[iopcw_pkg::IRQ_EN_BIT];
                iopcw_pkg::ADDR_CHANGE_STAT:
                    if (wdata8[iopcw_pkg::CHANGE_FLAG_BIT])
                        next_change_flag = 1'b0;
                default: next_change_flag = change_flag;
            endcase
        end
        // A read of port 5 takes a new reference for the detector
        if (rd && paddr_in == iopcw_pkg::ADDR_P5_DATA) begin
            next_port5_read_latch = pin_sync[7:0];
        end
        // A detected change wins over a clear in the same cycle
        if (pin_sync[7:0] != port5_read_latch) begin
            next_change_flag = 1'b1;
        end
    end

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            port5_data_reg <= iopcw_pkg::RST_DATA;
            port6_data_reg <= iopcw_pkg::RST_DATA;
            port7_data_reg <= iopcw_pkg::RST_DATA;
            port5_direction_reg <= iopcw_pkg::RST_DIR;
            port6_direction_reg <= iopcw_pkg::RST_DIR;
            port7_direction_reg <= iopcw_pkg::RST_DIR;
            port5_pulldown_reg <= iopcw_pkg::RST_PULLDOWN;
            port5_pullup_reg <= iopcw_pkg::RST_PULLUP;
            port6_opendrain_reg <= iopcw_pkg::RST_OPENDRAIN;
            port5_sink_strength_select <= iopcw_pkg::RST_STRENGTH;
            port6_sink_strength_select <= iopcw_pkg::RST_STRENGTH;
            port5_drive_strength_select <= iopcw_pkg::RST_STRENGTH;
            port6_drive_strength_select <= iopcw_pkg::RST_STRENGTH;
            port6_pullup_disable <= iopcw_pkg::RST_PULLUP;
            port_change_wake_en <= 1'b0;
            port_change_irq_en <= 1'b0;
            port5_read_latch <= 8'h00;
            change_flag <= 1'b0;
        end else begin
            port5_data_reg <= next_port5_data_reg;
            port6_data_reg <= next_port6_data_reg;
            port7_data_reg <= next_port7_data_reg;
            port5_direction_reg <= next_port5_direction_reg;
            port6_direction_reg <= next_port6_direction_reg;
            port7_direction_reg <= next_port7_direction_reg;
            port5_pulldown_reg <= next_port5_pulldown_reg;
            port5_pullup_reg <= next_port5_pullup_reg;
            port6_opendrain_reg <= next_port6_opendrain_reg;
            port5_sink_strength_select <= next_port5_sink_strength_select;
            port6_sink_strength_select <= next_port6_sink_strength_select;
            port5_drive_strength_select <= next_port5_drive_strength_select;
            port6_drive_strength_select <= next_port6_drive_strength_select;
            port6_pullup_disable <= next_port6_pullup_disable;
            port_change_wake_en <= next_port_change_wake_en;
            port_change_irq_en <= next_port_change_irq_en;
            port5_read_latch <= next_port5_read_latch;
            change_flag <= next_change_flag;
        end
    end

    // Pin drivers, one per pin
    genvar i;
    generate
        for (i = 0; i < 24; i++) begin : g_pin
            logic dat, dir, od;
            assign dat = (i < 8) ? port5_data_reg[i % 8] :
                         (i < 16) ? port6_data_reg[i % 8] :
                         port7_data_reg[i % 8];
            assign dir = (i < 8) ? port5_direction_reg[i % 8] :
                         (i < 16) ? port6_direction_reg[i % 8] :
                         port7_direction_reg[i % 8];
            assign od = (i >= 8 && i < 16) ? port6_opendrain_reg[i % 8] : 1'b0;
            // Open-drain pins only ever drive low
            always_comb begin
                next_pin_oe[i] = !dir && !(od && dat);
                next_pin_out[i] = dat && !od;
            end
        end
    endgenerate

    // Change event toward the core
    always_comb begin
        next_change_irq = change_flag && port_change_irq_en;
        next_change_wake = change_flag && port_change_wake_en
                           && core_sleeping_in;
        // Vector only with irq enable and global irq on, else next instr
        next_resume_vector = next_change_irq && global_irq_on_in;
    end

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            pin_out <= 24'h000000;
            pin_oe <= 24'h000000;
            change_irq <= 1'b0;
            change_wake <= 1'b0;
            resume_vector <= 1'b0;
        end else begin
            pin_out <= next_pin_out;
            pin_oe <= next_pin_oe;
            change_irq <= next_change_irq;
            change_wake <= next_change_wake;
            resume_vector <= next_resume_vector;
        end
    end

    // Outputs, all from flip-flops
    assign prdata_out = prdata;
    assign pready_out = pready;
    assign pslverr_out = pslverr;
    assign p5_pin_out = pin_out[7:0];
    assign p6_pin_out = pin_out[15:8];
    assign p7_pin_out = pin_out[23:16];
    assign p5_pin_oe_out = pin_oe[7:0];
    assign p6_pin_oe_out = pin_oe[15:8];
    assign p7_pin_oe_out = pin_oe[23:16];
    assign p5_pulldown_n_out = port5_pulldown_reg;
    assign p5_pullup_n_out = port5_pullup_reg;
    assign p6_pullup_n_out = port6_pullup_disable;
    assign p5_sink_strength_sel_out = port5_sink_strength_select;
    assign p6_sink_strength_sel_out = port6_sink_strength_select;
    assign p5_drive_strength_sel_out = port5_drive_strength_select;
    assign p6_drive_strength_sel_out = port6_drive_strength_select;
    assign change_irq_out = change_irq;
    assign change_wake_out = change_wake;
    assign resume_vector_out = resume_vector;
endmodule

// *** testbench/iopcw_sva.sv ***
// Port checks for the GPIO port and change wake block
`timescale 1ns/1ps
module iopcw_sva (
    input wire logic clk_in,
    input wire logic reset_n_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [7:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    input wire logic [31:0] prdata_out,
    input wire logic pready_out,
    input wire logic pslverr_out,
    input wire logic [7:0] p7_pin_oe_out,
    input wire logic [7:0] p6_pullup_n_out,
    input wire logic [7:0] p5_sink_strength_sel_out,
    input wire logic [7:0] p5_drive_strength_sel_out,
    input wire logic core_sleeping_in,
    input wire logic global_irq_on_in,
    input wire logic change_wake_out,
    input wire logic resume_vector_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!reset_n_in);
    logic done;
    assign done = psel_in && penable_in && pready_out;
    chk_ready_wait: assert property (
        $rose(penable_in) && psel_in |-> !pready_out ##1 pready_out)
        else $error("ready not after one wait state");
    chk_ready_pulse: assert property (pready_out |=> !pready_out)
        else $error("ready held longer than one cycle");
    chk_unmapped_err: assert property (
        done && paddr_in > iopcw_pkg::ADDR_CHANGE_STAT |->
        pslverr_out && (pwrite_in || prdata_out == 32'h0))
        else $error("unmapped access not refused");
    chk_mapped_ok: assert property (done && paddr_in[1:0] == 2'b00 &&
        paddr_in <= iopcw_pkg::ADDR_CHANGE_STAT |-> !pslverr_out)
        else $error("mapped access refused");
    chk_p5_str_gap: assert property (
        ((p5_sink_strength_sel_out | p5_drive_strength_sel_out) &
        8'h21) == 8'h00)
        else $error("unused strength bit set");
    chk_dir_to_oe: assert property (
        done && pwrite_in && paddr_in == iopcw_pkg::ADDR_P7_DIR |->
        ##2 p7_pin_oe_out == ~$past(pwdata_in[7:0], 2))
        else $error("enable does not follow direction");
    chk_pullup_write: assert property (
        done && pwrite_in && paddr_in == iopcw_pkg::ADDR_P6_PULLUP |=>
        p6_pullup_n_out == $past(pwdata_in[7:0]))
        else $error("pull-up enables do not follow write");
    chk_vector_gate: assert property (
        resume_vector_out |-> $past(global_irq_on_in))
        else $error("vector taken with global interrupts off");
    chk_wake_sleep: assert property (
        change_wake_out |-> $past(core_sleeping_in))
        else $error("wake raised while core awake");
endmodule
bind iopcw_top iopcw_sva iopcw_sva_inst (.clk_in(clk_in),
    .reset_n_in(reset_n_in), .psel_in(psel_in), .penable_in(penable_in),
    .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
    .prdata_out(prdata_out), .pready_out(pready_out),
    .pslverr_out(pslverr_out), .p7_pin_oe_out(p7_pin_oe_out),
    .p6_pullup_n_out(p6_pullup_n_out),
    .p5_sink_strength_sel_out(p5_sink_strength_sel_out),
    .p5_drive_strength_sel_out(p5_drive_strength_sel_out),
    .core_sleeping_in(core_sleeping_in),
    .global_irq_on_in(global_irq_on_in),
    .change_wake_out(change_wake_out),
    .resume_vector_out(resume_vector_out));

// *** testbench/iopcw_board_model.sv ***
// Board model: external drivers, pulls and floating pins
`timescale 1ns/1ps
module iopcw_board_model (
    input wire logic clk_in,
    input wire logic [23:0] drv_in,
    input wire logic [23:0] oe_in,
    input wire logic [23:0] ext_in,
    input wire logic [23:0] ext_en_in,
    input wire logic [23:0] pullup_n_in,
    input wire logic [23:0] pulldown_n_in,
    output logic [23:0] level_out
);
    logic float_q = 1'b0;
    // Undriven pins without pulls change every cycle
    always_ff @(posedge clk_in) begin
        float_q <= ~float_q;
    end
    always_comb begin
        for (int i = 0; i < 24; i++) begin
            if (oe_in[i]) level_out[i] = drv_in[i];
            else if (ext_en_in[i]) level_out[i] = ext_in[i];
            else if (!pullup_n_in[i]) level_out[i] = 1'b1;
            else if (!pulldown_n_in[i]) level_out[i] = 1'b0;
            else level_out[i] = float_q;
        end
    end
endmodule

// *** testbench/iopcw_top_test.sv ***
// Self-checking bench for the GPIO port and change wake block
`timescale 1ns/1ps
module iopcw_top_test;
    logic clk, reset_n, psel, penable, pwrite, pready, pslverr, err;
    logic sleeping, gie, irq, wake, vec;
    logic [7:0] paddr, p5_hs, p6_hs, p5_hd, p6_hd, pd5_n, pu5_n, pu6_n;
    logic [31:0] pwdata, prdata, rd;
    logic [23:0] lvl, drv, oe, ext, ext_en;
    int fails, checks;
    iopcw_top iopcw_top_inst (.clk_in(clk), .reset_n_in(reset_n),
        .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
        .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
        .pready_out(pready), .pslverr_out(pslverr), .p5_pin_in(lvl[7:0]),
        .p6_pin_in(lvl[15:8]), .p7_pin_in(lvl[23:16]),
        .p5_pin_out(drv[7:0]), .p6_pin_out(drv[15:8]),
        .p7_pin_out(drv[23:16]), .p5_pin_oe_out(oe[7:0]),
        .p6_pin_oe_out(oe[15:8]), .p7_pin_oe_out(oe[23:16]),
        .p5_pulldown_n_out(pd5_n), .p5_pullup_n_out(pu5_n),
        .p6_pullup_n_out(pu6_n), .p5_sink_strength_sel_out(p5_hs),
        .p6_sink_strength_sel_out(p6_hs), .p5_drive_strength_sel_out(p5_hd),
        .p6_drive_strength_sel_out(p6_hd), .core_sleeping_in(sleeping),
        .global_irq_on_in(gie), .change_irq_out(irq),
        .change_wake_out(wake), .resume_vector_out(vec));
    iopcw_board_model iopcw_board_model_inst (.clk_in(clk), .drv_in(drv),
        .oe_in(oe), .ext_in(ext), .ext_en_in(ext_en),
        .pullup_n_in({8'hFF, pu6_n, pu5_n}),
        .pulldown_n_in({16'hFFFF, pd5_n}), .level_out(lvl));
    task automatic summarize;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input string name, input logic [31:0] exp, got);
        checks++;
        if (got !== exp) begin
            $display("ERROR %s expected %h seen %h", name, exp, got);
            fails++;
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input int d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 16) begin
            fails++;
            summarize();
        end
        @(posedge clk);
    endtask
    task automatic rdc(input string name, input logic [7:0] a, input int e);
        apb(1'b0, a, 0);
        chk(name, e, rd);
        chk("slverr", {31'h0, a > 8'h40}, {31'h0, err});
    endtask
    task automatic wait_for(input logic sel);
        int n;
        n = 0;
        while ((sel ? wake : irq) !== 1'b1 && n < 12) begin
            @(posedge clk);
            n++;
        end
        chk("event seen", 1, {31'h0, n < 12});
        if (n >= 12) summarize();
    endtask
    task automatic s_reset;
        rdc("p5 dir", iopcw_pkg::ADDR_P5_DIR, 8'hFF);
        rdc("p6 dir", iopcw_pkg::ADDR_P6_DIR, 8'hFF);
        rdc("p7 dir", iopcw_pkg::ADDR_P7_DIR, 8'hFF);
        rdc("p5 down", iopcw_pkg::ADDR_P5_PULLDOWN, 8'hFF);
        rdc("p6 od", iopcw_pkg::ADDR_P6_OPENDRAIN, 8'h00);
        chk("oe", 0, oe);
        rdc("unmapped", 8'h44, 0);
    endtask
    task automatic s_regs;
        logic [7:0] pat, e, seen;
        logic [7:0] at [7] = '{8'h24, 8'h28, 8'h2C, 8'h30, 8'h34,
            8'h1C, 8'h18};
        for (int p = 0; p < 3; p++) begin
            pat = (p == 0) ? 8'hFF : (p == 1) ? 8'h21 : 8'h5A;
            for (int i = 0; i < 7; i++) begin
                e = (i == 0 || i == 2) ? (pat & 8'hDE) : pat;
                apb(1'b1, at[i], pat);
                rdc("cfg read", at[i], e);
                case (i)
                    0: seen = p5_hs;
                    1: seen = p6_hs;
                    2: seen = p5_hd;
                    3: seen = p6_hd;
                    4: seen = pu6_n;
                    5: seen = pu5_n;
                    default: seen = pd5_n;
                endcase
                chk("cfg out", e, seen);
            end
        end
    endtask
    task automatic s_ports;
        apb(1'b1, iopcw_pkg::ADDR_P7_DATA, 8'hA5);
        apb(1'b1, iopcw_pkg::ADDR_P7_DIR, 8'h0F);
        apb(1'b1, iopcw_pkg::ADDR_P6_PULLUP, 8'h00);
        apb(1'b1, iopcw_pkg::ADDR_P6_DATA, 8'h0F);
        apb(1'b1, iopcw_pkg::ADDR_P6_OPENDRAIN, 8'h33);
        apb(1'b1, iopcw_pkg::ADDR_P6_DIR, 8'h00);
        repeat (4) @(posedge clk);
        chk("p7 oe/out", 16'hF0A5, {oe[23:16], drv[23:16]});
        chk("p6 oe/out", 16'hFC0C, {oe[15:8], drv[15:8]});
        rdc("p7 pins", iopcw_pkg::ADDR_P7_DATA, 8'hAC);
        rdc("p6 pins", iopcw_pkg::ADDR_P6_DATA, 8'h0F);
        apb(1'b1, iopcw_pkg::ADDR_P6_OPENDRAIN, 8'h00);
        repeat (3) @(posedge clk);
        chk("p6 push", 16'hFF0F, {oe[15:8], drv[15:8]});
        apb(1'b1, iopcw_pkg::ADDR_P5_DATA, 8'hC3);
        apb(1'b1, iopcw_pkg::ADDR_P5_DIR, 8'h00);
        repeat (3) @(posedge clk);
        chk("p5 oe/out", 16'hFFC3, {oe[7:0], drv[7:0]});
        apb(1'b1, iopcw_pkg::ADDR_P5_DIR, 8'hFF);
        repeat (4) @(posedge clk);
        chk("p5 released", 0, oe[7:0]);
    endtask
    task automatic s_change;
        rdc("p5 read", iopcw_pkg::ADDR_P5_DATA, 8'h5A);
        apb(1'b1, iopcw_pkg::ADDR_CHANGE_STAT, 1);
        gie <= 1'b1;
        apb(1'b1, iopcw_pkg::ADDR_IRQ_EN, 2);
        repeat (4) @(posedge clk);
        chk("quiet", 0, {irq, wake});
        ext[0] <= 1'b1;
        wait_for(1'b0);
        @(posedge clk);
        chk("vector", 1, vec);
        gie <= 1'b0;
        ext[0] <= 1'b0;
        repeat (5) @(posedge clk);
        chk("sticky next", 2, {irq, vec});
        rdc("p5 read", iopcw_pkg::ADDR_P5_DATA, 8'h5A);
        apb(1'b1, iopcw_pkg::ADDR_CHANGE_STAT, 1);
        apb(1'b1, iopcw_pkg::ADDR_IRQ_EN, 0);
        apb(1'b1, iopcw_pkg::ADDR_WAKE_CTRL, 2);
        sleeping <= 1'b1;
        repeat (5) @(posedge clk);
        chk("cleared", 0, {irq, wake});
        ext[7] <= 1'b1;
        wait_for(1'b1);
        chk("wake only", 0, {irq, vec});
    endtask
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    initial begin
        reset_n = 1'b0;
        {psel, penable, pwrite, sleeping, gie} = 5'h00;
        paddr = 8'h00;
        pwdata = 32'h0;
        ext = 24'h3C005A;
        ext_en = 24'h0F00FF;
        fails = 0;
        checks = 0;
        repeat (12) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        s_reset();
        s_regs();
        s_ports();
        s_change();
        summarize();
    end
endmodule
